/* File: bench/fws_flash_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// flash model: array reads or write status
module fws_flash_model
   import fws_pkg::*;
#(
   parameter int BUSY_RD = 4
)
(
   input  wire logic [FLASH_AW-1:0] addr_in,
   input  wire logic                ce_n_in,
   input  wire logic                oe_n_in,
   input  wire logic                we_n_in,
   input  wire logic [7:0]          dq_in,
   output var  logic [7:0]          dq_out
);
   logic [7:0]          mem [0:255];
   logic [7:0]          pd_q, prev_q, last_q, rd;
   logic [FLASH_AW-1:0] pa_q;
   logic [4:0]          sec_q;
   logic                pgm_q, er_q, sus_q, bad_q, fl_q, tog_q;
   int                  left_q;
   wire                 insec = addr_in[17:13] == sec_q;

   initial
   begin
      foreach (mem[i]) mem[i] = 8'hFF;
      {pgm_q, er_q, sus_q, bad_q, fl_q, tog_q} = 6'h00;
      {prev_q, last_q, sec_q} = 21'h00000;
      left_q = 0;
   end

   always @(posedge we_n_in)
   begin
      if (prev_q == 8'hA0)
      begin
         pa_q   = addr_in;
         pd_q   = dq_in;
         pgm_q  = 1'h1;
         left_q = BUSY_RD;
         bad_q  = addr_in[17:13] != 5'h1F && |(dq_in & ~mem[addr_in[7:0]]);
      end
      else if (dq_in == CMD_RESET)
         {pgm_q, er_q, sus_q, fl_q} = 4'h0;
      else if (dq_in == 8'h30 && prev_q == 8'h55)
      begin
         {er_q, sus_q} = 2'h2;
         sec_q  = addr_in[17:13];
         left_q = BUSY_RD;
      end
      else if (dq_in == 8'hB0 && er_q)
         sus_q = 1'h1;
      else if (dq_in == 8'h30 && sus_q)
      begin
         sus_q  = 1'h0;
         left_q = BUSY_RD;
      end
      // program data never opens a new command
      prev_q = (prev_q == 8'hA0) ? 8'h00 : dq_in;
   end

   always @(posedge oe_n_in)
   begin
      last_q = rd;
      tog_q  = ~tog_q;
      if ((pgm_q || (er_q && !sus_q)) && !fl_q && left_q > 0)
         left_q--;
      if (pgm_q && !fl_q && left_q == 0)
      begin
         fl_q = bad_q;
         if (!bad_q && pa_q[17:13] != 5'h1F)
            mem[pa_q[7:0]] = pd_q;
         pgm_q = bad_q;
      end
      else if (er_q && !sus_q && !pgm_q && left_q == 0)
      begin
         if (sec_q != 5'h1F)
            foreach (mem[i]) mem[i] = 8'hFF;
         er_q = 1'h0;
      end
   end

   always @*
   begin
      if (pgm_q)
         rd = {~pd_q[7], tog_q, fl_q, 5'h00};
      else if (er_q && (insec || !sus_q))
         rd = {sus_q, tog_q & ~sus_q, 3'h0, tog_q & insec, 2'h0};
      else
         rd = mem[addr_in[7:0]];
      // released bus must not keep the old value
      dq_out = (ce_n_in || oe_n_in) ? ~last_q : rd;
   end
endmodule : fws_flash_model
`default_nettype wire

/* File: bench/test_fws_status_poller.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// bench: poller against the flash model
module test_fws_status_poller
   import fws_pkg::*;
;
   logic                clk = 1'h0, srst = 1'h1, rd_r = 1'h0, wr_r = 1'h0;
   logic [3:0]          adr = 4'h0;
   logic [31:0]         wd = 32'h0, rdata;
   logic                wreq, ce_n, oe_n, we_n, drv_n;
   logic [FLASH_AW-1:0] fa, pa;
   logic [7:0]          cdq, mdq, pd;
   wire  [7:0]          bus_dq = drv_n ? mdq : cdq;
   int                  err_count = 0, total_checks = 0;

   always #5 clk = ~clk;

   fws_status_poller #(.POLL_MAX(8)) fws_status_poller_i (
      .CLK_IN(clk), .SRST_IN(srst), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd_r), .AVS_WRITE_IN(wr_r),
      .AVS_WRITEDATA_IN(wd), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq), .FL_ADDR_OUT(fa),
      .FL_CE_N_OUT(ce_n), .FL_OE_N_OUT(oe_n), .FL_WE_N_OUT(we_n), .FL_DQ_IN(bus_dq), .FL_DQ_OUT(cdq),
      .FL_DQ_DRV_N_OUT(drv_n));

   fws_flash_model #(.BUSY_RD(4)) fws_flash_model_i (
      .addr_in(fa), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .dq_in(bus_dq), .dq_out(mdq));

   // ==========================================
   // report and compare
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   function automatic logic [31:0] stv(input logic d, input logic f, input logic t, input logic s);
      stv = 32'h0;
      stv[STAT_DONE] = d;
      stv[STAT_FAIL] = f;
      stv[STAT_TMO]  = t;
      stv[STAT_STOG] = s;
   endfunction : stv

   // ==========================================
   // avalon access, held until waitrequest low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clk);
      adr  <= a;
      wd   <= d;
      wr_r <= w;
      rd_r <= ~w;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wreq !== 1'h0 && n < 50);
      r = rdata;
      wr_r <= 1'h0;
      rd_r <= 1'h0;
      if (n >= 50)
         err_count++;
      if (n >= 50)
         complete_run();
   endtask : bus

   task automatic op(input logic [2:0] c, input logic [17:0] a, input logic [7:0] d, output logic [31:0] s);
      int n;
      bus(1'h1, REG_ADDR, {14'h0, a}, s);
      bus(1'h1, REG_DATA, {24'h0, d}, s);
      bus(1'h1, REG_CTRL, {29'h0, c}, s);
      n = 0;
      do
      begin
         bus(1'h0, REG_STAT, 32'h0, s);
         n++;
      end
      while (s[STAT_BUSY] !== 1'h0 && n < 400);
      if (n >= 400)
         err_count++;
      if (n >= 400)
         complete_run();
   endtask : op

   task automatic cmd(input logic [7:0] b);
      logic [31:0] s;
      op(OP_WRITE, 18'h00555, 8'hAA, s);
      op(OP_WRITE, 18'h002AA, 8'h55, s);
      op(OP_WRITE, 18'h00555, b, s);
   endtask : cmd

   task automatic rd_byte(input logic [17:0] a, input logic [7:0] e);
      logic [31:0] s;
      op(OP_READ, a, 8'h00, s);
      bus(1'h0, REG_DATA, 32'h0, s);
      chk("array byte", {24'h0, e}, s);
   endtask : rd_byte

   initial
   begin
      logic [31:0] st;
      void'($urandom(32'hBC6C));
      repeat (16) @(posedge clk);
      srst <= 1'h0;
      bus(1'h0, 4'h2, 32'h0, st);
      chk("unmapped read", 32'h0, st);
      // random programs, both poll styles
      for (int i = 0; i < 4; i++)
      begin
         pa = {5'($urandom_range(0, 30)), 5'h00, 8'(i)};
         // bit 2 kept low: last toggle pair may mix status and array
         pd = 8'($urandom) & 8'hFA;
         cmd(8'hA0);
         op(OP_WRITE, pa, pd, st);
         op(i[0] ? OP_TPOLL : OP_DPOLL, pa, pd, st);
         chk("poll after program", stv(1, 0, 0, 0), st);
         rd_byte(pa, pd);
      end
      $display("end of test: programs");
      // finished byte never matches inverse datum
      cmd(8'hA0);
      op(OP_WRITE, 18'h00010, 8'h80, st);
      op(OP_TPOLL, 18'h00010, 8'h80, st);
      op(OP_DPOLL, 18'h00010, 8'h00, st);
      chk("poll timeout", stv(0, 0, 1, 0), st);
      // one over zero trips the limit bit
      cmd(8'hA0);
      op(OP_WRITE, 18'h00010, 8'hFF, st);
      op(OP_DPOLL, 18'h00010, 8'hFF, st);
      chk("limit failure", stv(0, 1, 0, 0), st);
      rd_byte(18'h00010, 8'h80);
      // toggle poll on a failing program takes the recheck path
      cmd(8'hA0);
      op(OP_WRITE, 18'h00010, 8'hFF, st);
      op(OP_TPOLL, 18'h00010, 8'hFF, st);
      chk("toggle limit failure", stv(1'h0, 1'h1, 1'h0, 1'h0) | (32'h1 << STAT_GTOG), st);
      op(OP_RESET, 18'h00000, 8'h00, st);
      chk("reset command", stv(1'h1, 1'h0, 1'h0, 1'h0), st);
      bus(1'h0, REG_CTRL, 32'h0, st);
      chk("op readback", {29'h0, OP_RESET}, st);
      rd_byte(18'h00010, 8'h80);
      $display("end of test: failures");
      // protected sector program
      cmd(8'hA0);
      op(OP_WRITE, 18'h3E010, 8'h00, st);
      op(OP_TPOLL, 18'h3E010, 8'h00, st);
      chk("protected program", stv(1, 0, 0, 0), st);
      rd_byte(18'h3E010, 8'h80);
      $display("end of test: protected");
      // sector erase, suspend, program, resume
      cmd(8'h80);
      op(OP_WRITE, 18'h00555, 8'hAA, st);
      op(OP_WRITE, 18'h002AA, 8'h55, st);
      op(OP_WRITE, 18'h06040, 8'h30, st);
      op(OP_WRITE, 18'h06040, 8'hB0, st);
      op(OP_TPOLL, 18'h06040, 8'hFF, st);
      chk("suspended sector", stv(1, 0, 0, 1), st);
      op(OP_TPOLL, 18'h08050, 8'hFF, st);
      chk("other sector", stv(1, 0, 0, 0), st);
      op(OP_DPOLL, 18'h06040, 8'hFF, st);
      chk("suspend data poll", stv(1, 0, 0, 0), st);
      cmd(8'hA0);
      op(OP_WRITE, 18'h08050, 8'h12, st);
      op(OP_TPOLL, 18'h08050, 8'h12, st);
      chk("suspend program", stv(1, 0, 0, 0), st);
      op(OP_WRITE, 18'h06040, 8'h30, st);
      op(OP_DPOLL, 18'h06040, 8'hFF, st);
      chk("erase done", stv(1, 0, 0, 0), st);
      rd_byte(18'h00010, 8'hFF);
      $display("end of test: erase");
      complete_run();
   end
endmodule : test_fws_status_poller
`default_nettype wire

/* File: hw/fws_bus_cycle.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// one read or write cycle on the flash pins
module fws_bus_cycle
   import fws_pkg::*;
#(
   parameter int AW    = FLASH_AW,
   parameter int PULSE = PULSE_CYC,
   parameter int RECOV = RECOV_CYC
)
(
   input  wire logic          clk_in,
   input  wire logic          srst_in,
   input  wire logic          start_in,
   input  wire logic          is_write_in,
   input  wire logic [AW-1:0] addr_in,
   input  wire logic [7:0]    wdata_in,
   input  wire logic [7:0]    dq_in,
   output var  logic          done_out,
   output var  logic [7:0]    rdata_out,
   output var  logic [AW-1:0] fl_addr_out,
   output var  logic          ce_n_out,
   output var  logic          oe_n_out,
   output var  logic          we_n_out,
   output var  logic [7:0]    dq_out,
   output var  logic          dq_drv_n_out
);

   localparam int CW = $clog2(((PULSE > RECOV) ? PULSE : RECOV) + 1);
   localparam logic [CW-1:0] PULSE_LAST = CW'(PULSE - 1);
   localparam logic [CW-1:0] RECOV_LAST = CW'(RECOV - 1);

   if (PULSE < 1 || RECOV < 1)
   begin : g_chk
      $error("fws_bus_cycle: pulse and recovery need one cycle at least");
   end

   typedef enum {C_IDLE, C_SETUP, C_ACT, C_HOLD} fws_cyc_t;

   fws_cyc_t       st_q;
   logic [CW-1:0]  cnt_q;
   logic           wr_q;

   wire act_last  = (st_q == C_ACT) && (cnt_q == PULSE_LAST);
   wire hold_last = (st_q == C_HOLD) && (cnt_q == RECOV_LAST);

   // ==========================================
   // every read is a fresh chip-select/strobe pulse so toggle bits advance
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         st_q         <= C_IDLE;
         cnt_q        <= '0;
         wr_q         <= 1'b0;
         done_out     <= 1'b0;
         rdata_out    <= 8'h00;
         fl_addr_out  <= '0;
         ce_n_out     <= 1'b1;
         oe_n_out     <= 1'b1;
         we_n_out     <= 1'b1;
         dq_out       <= 8'h00;
         dq_drv_n_out <= 1'b1;
      end
      else
      begin
         done_out <= hold_last;
         case (st_q)
            C_IDLE:
            begin
               if (start_in)
               begin
                  st_q        <= C_SETUP;
                  wr_q        <= is_write_in;
                  fl_addr_out <= addr_in;
                  dq_out      <= wdata_in;
               end
            end
            C_SETUP:
            begin
               st_q         <= C_ACT;
               cnt_q        <= '0;
               ce_n_out     <= 1'b0;
               oe_n_out     <= wr_q;
               we_n_out     <= ~wr_q;
               dq_drv_n_out <= ~wr_q;
            end
            C_ACT:
            begin
               cnt_q <= cnt_q + 1'b1;
               if (act_last)
               begin
                  st_q     <= C_HOLD;
                  cnt_q    <= '0;
                  ce_n_out <= 1'b1;
                  oe_n_out <= 1'b1;
                  we_n_out <= 1'b1;
                  if (!wr_q)
                  begin
                     rdata_out <= dq_in;
                  end
               end
            end
            default:
            begin
               cnt_q <= cnt_q + 1'b1;
               if (hold_last)
               begin
                  st_q         <= C_IDLE;
                  dq_drv_n_out <= 1'b1;
               end
            end
         endcase
      end
   end

endmodule : fws_bus_cycle
`default_nettype wire

/* File: hw/fws_status_poller.sv */
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module fws_status_poller
   import fws_pkg::*;
#(
   parameter int POLL_MAX = POLL_MAX_DEF
)
(
   input  wire logic                CLK_IN,
   input  wire logic                SRST_IN,
   input  wire logic [3:0]          AVS_ADDRESS_IN,
   input  wire logic                AVS_READ_IN,
   input  wire logic                AVS_WRITE_IN,
   input  wire logic [31:0]         AVS_WRITEDATA_IN,
   output var  logic [31:0]         AVS_READDATA_OUT,
   output var  logic                AVS_WAITREQUEST_OUT,
   output var  logic [FLASH_AW-1:0] FL_ADDR_OUT,
   output var  logic                FL_CE_N_OUT,
   output var  logic                FL_OE_N_OUT,
   output var  logic                FL_WE_N_OUT,
   input  wire logic [7:0]          FL_DQ_IN,
   output var  logic [7:0]          FL_DQ_OUT,
   output var  logic                FL_DQ_DRV_N_OUT
);

   localparam int CNTW = $clog2(POLL_MAX + 1);
   localparam logic [CNTW-1:0] POLL_LAST = CNTW'(POLL_MAX - 1);

   if (POLL_MAX < 2)
   begin : g_chk
      $error("fws_status_poller: POLL_MAX must be at least 2");
   end

   typedef enum {ST_IDLE, ST_WR, ST_RD, ST_DP_A, ST_DP_B, ST_TG_A, ST_TG_B, ST_TG_C,
                 ST_FINAL, ST_RESET} fws_state_t;

   fws_state_t          state_q;
   fws_state_t          state_d;
   fws_op_t             op_q;
   logic [FLASH_AW-1:0] valid_poll_address_q;
   logic [7:0]          data_q;
   logic [7:0]          rdata_q;
   logic [7:0]          prev_q;
   logic [CNTW-1:0]     cnt_q;
   logic                issued_q;
   logic                done_q;
   logic                fail_q;
   logic                tmo_q;
   logic                gtog_q;
   logic                stog_q;
   logic                set_ok;
   logic                set_fail;
   logic                set_tmo;
   logic                set_tog;
   logic                cyc_done;
   logic [7:0]          cyc_rdata;

   // ==========================================
   // avalon decode
   wire acc_wr   = AVS_WRITE_IN & ~AVS_WAITREQUEST_OUT;
   wire wr_ctrl  = acc_wr && (AVS_ADDRESS_IN == REG_CTRL);
   wire wr_addr  = acc_wr && (AVS_ADDRESS_IN == REG_ADDR) && (state_q == ST_IDLE);
   wire wr_data  = acc_wr && (AVS_ADDRESS_IN == REG_DATA) && (state_q == ST_IDLE);
   // commands written while busy are dropped; busy bit shows why
   wire cmd_go   = wr_ctrl && (state_q == ST_IDLE);
   wire busy     = (state_q != ST_IDLE);
   wire [OP_W-1:0] new_op = AVS_WRITEDATA_IN[OP_W-1:0];

   wire [STAT_W-1:0] stat_word = {stog_q, gtog_q, tmo_q, fail_q, done_q, busy};
   wire [31:0] rd_mux = (AVS_ADDRESS_IN == REG_CTRL) ? {{(32-OP_W){1'b0}}, op_q} :
                        (AVS_ADDRESS_IN == REG_ADDR) ? {{(32-FLASH_AW){1'b0}}, valid_poll_address_q} :
                        (AVS_ADDRESS_IN == REG_DATA) ? {24'h000000, rdata_q} :
                        (AVS_ADDRESS_IN == REG_STAT) ? {{(32-STAT_W){1'b0}}, stat_word} :
                        32'h00000000;

   // ==========================================
   // status bit evaluation on each finished read
   // expected bit 7 compare
   // erase polls expect bit 7 high, software loads FF
   wire dp_match    = cyc_rdata[DATA_POLL_BIT] == data_q[DATA_POLL_BIT];
   wire lim_fail    = cyc_rdata[TIMING_LIMIT_FAIL_BIT];
   wire g_changed   = cyc_rdata[GLOBAL_TOGGLE_BIT] ^ prev_q[GLOBAL_TOGGLE_BIT];
   wire s_changed   = cyc_rdata[SECTOR_TOGGLE_BIT] ^ prev_q[SECTOR_TOGGLE_BIT];
   wire poll_expire = (cnt_q == POLL_LAST);
   wire polling     = (state_q == ST_DP_A) || (state_q == ST_DP_B) || (state_q == ST_TG_A) ||
                      (state_q == ST_TG_B) || (state_q == ST_TG_C) || (state_q == ST_FINAL);
   wire cyc_start   = busy && !issued_q;
   wire cyc_write   = (state_q == ST_WR) || (state_q == ST_RESET);
   wire [7:0] cyc_wdata = (state_q == ST_RESET) ? CMD_RESET : data_q;

   function automatic fws_state_t fws_op_entry(input logic [OP_W-1:0] op);
      fws_state_t s;
      s = ST_IDLE;
      if (op == OP_WRITE)
         s = ST_WR;
      else if (op == OP_READ)
         s = ST_RD;
      else if (op == OP_DPOLL)
         s = ST_DP_A;
      else if (op == OP_TPOLL)
         s = ST_TG_A;
      else if (op == OP_RESET)
         s = ST_RESET;
      return s;
   endfunction : fws_op_entry

   // ==========================================
   // poll sequencer
   always_comb
   begin
      state_d  = state_q;
      set_ok   = 1'b0;
      set_fail = 1'b0;
      set_tmo  = 1'b0;
      set_tog  = 1'b0;
      case (state_q)
         ST_IDLE:
         begin
            if (cmd_go)
               state_d = fws_op_entry(new_op);
         end
         ST_WR, ST_RD:
         begin
            if (cyc_done)
            begin
               state_d = ST_IDLE;
               set_ok  = 1'b1;
            end
         end
         ST_DP_A:
         begin
            if (cyc_done)
            begin
               // true bit 7 seen, data comes from the next read
               if (dp_match)
                  state_d = ST_FINAL;
               // fail bit up, bit 7 gets one more look
               else if (lim_fail)
                  state_d = ST_DP_B;
               else if (poll_expire)
               begin
                  state_d = ST_IDLE;
                  set_tmo = 1'b1;
               end
            end
         end
         ST_DP_B:
         begin
            if (cyc_done)
               state_d = dp_match ? ST_FINAL : ST_RESET;
         end
         ST_TG_A:
         begin
            if (cyc_done)
               state_d = ST_TG_B;
         end
         ST_TG_B:
         begin
            if (cyc_done)
            begin
               // bit 6 gives mode, bit 2 gives sector
               if (!g_changed)
               begin
                  state_d = ST_FINAL;
                  set_tog = 1'b1;
               end
               else if (lim_fail)
                  state_d = ST_TG_C;
               else if (poll_expire)
               begin
                  state_d = ST_IDLE;
                  set_tmo = 1'b1;
               end
            end
         end
         ST_TG_C:
         begin
            if (cyc_done)
               state_d = g_changed ? ST_RESET : ST_FINAL;
         end
         ST_FINAL:
         begin
            if (cyc_done)
            begin
               state_d = ST_IDLE;
               set_ok  = 1'b1;
            end
         end
         default:
         begin
            // reset command written after a failure or for an OP_RESET command
            if (cyc_done)
            begin
               state_d  = ST_IDLE;
               set_fail = (op_q != OP_RESET);
               set_ok   = (op_q == OP_RESET);
            end
         end
      endcase
   end

   // ==========================================
   // sequencer registers
   always_ff @(posedge CLK_IN)
   begin
      if (SRST_IN)
      begin
         state_q  <= ST_IDLE;
         issued_q <= 1'b0;
         cnt_q    <= '0;
         prev_q   <= 8'h00;
         rdata_q  <= 8'h00;
      end
      else
      begin
         state_q  <= state_d;
         issued_q <= cyc_start | (issued_q & ~cyc_done);
         if (cmd_go)
            cnt_q <= '0;
         else if (cyc_done && polling)
            cnt_q <= cnt_q + 1'b1;
         if (cyc_done)
         begin
            prev_q <= cyc_rdata;
            if (!cyc_write)
               rdata_q <= cyc_rdata;
         end
      end
   end

   // ==========================================
   // software registers and flags, a set beats the clearing command except on gtog_q, where the command clears first
   always_ff @(posedge CLK_IN)
   begin
      if (SRST_IN)
      begin
         op_q                 <= OP_NONE;
         valid_poll_address_q <= '0;
         data_q               <= 8'h00;
         done_q               <= 1'b0;
         fail_q               <= 1'b0;
         tmo_q                <= 1'b0;
         gtog_q               <= 1'b0;
         stog_q               <= 1'b0;
      end
      else
      begin
         if (cmd_go)
            op_q <= fws_op_t'(new_op);
         if (wr_addr)
            valid_poll_address_q <= AVS_WRITEDATA_IN[FLASH_AW-1:0];
         if (wr_data)
            data_q <= AVS_WRITEDATA_IN[7:0];
         done_q <= set_ok | (done_q & ~cmd_go);
         fail_q <= set_fail | (fail_q & ~cmd_go);
         tmo_q  <= set_tmo | (tmo_q & ~cmd_go);
         gtog_q <= (set_tog | cmd_go) ? 1'b0 : (gtog_q | (state_q == ST_TG_B && cyc_done && g_changed));
         stog_q <= set_tog ? s_changed : (stog_q & ~cmd_go);
      end
   end

   // ==========================================
   // avalon answer: one wait cycle, then the access completes
   always_ff @(posedge CLK_IN)
   begin
      if (SRST_IN)
      begin
         AVS_WAITREQUEST_OUT <= 1'b1;
         AVS_READDATA_OUT    <= 32'h00000000;
      end
      else
      begin
         if (AVS_WAITREQUEST_OUT && (AVS_READ_IN || AVS_WRITE_IN))
         begin
            AVS_WAITREQUEST_OUT <= 1'b0;
            AVS_READDATA_OUT    <= rd_mux;
         end
         else
            AVS_WAITREQUEST_OUT <= 1'b1;
      end
   end

   fws_bus_cycle #(
      .AW    (FLASH_AW),
      .PULSE (PULSE_CYC),
      .RECOV (RECOV_CYC)
   ) u_cyc (
      .clk_in       (CLK_IN),
      .srst_in      (SRST_IN),
      .start_in     (cyc_start),
      .is_write_in  (cyc_write),
      .addr_in      (valid_poll_address_q),
      .wdata_in     (cyc_wdata),
      .dq_in        (FL_DQ_IN),
      .done_out     (cyc_done),
      .rdata_out    (cyc_rdata),
      .fl_addr_out  (FL_ADDR_OUT),
      .ce_n_out     (FL_CE_N_OUT),
      .oe_n_out     (FL_OE_N_OUT),
      .we_n_out     (FL_WE_N_OUT),
      .dq_out       (FL_DQ_OUT),
      .dq_drv_n_out (FL_DQ_DRV_N_OUT)
   );

   // ==========================================
   // checks
   a_poll_addr_match: assert property (
      @(posedge CLK_IN) disable iff (SRST_IN)
      (polling && !FL_OE_N_OUT) |-> (FL_ADDR_OUT == valid_poll_address_q))
      else $error("poll read not at the poll address");

   a_poll_addr_stable: assert property (
      @(posedge CLK_IN) disable iff (SRST_IN)
      (polling && $past(polling) && !cmd_go) |-> $stable(valid_poll_address_q))
      else $error("poll address moved during polling");

   a_strobe_addr_set: assert property (
      @(posedge CLK_IN) disable iff (SRST_IN)
      ($fell(FL_OE_N_OUT) && polling) |-> (FL_ADDR_OUT == valid_poll_address_q) && FL_DQ_DRV_N_OUT)
      else $error("poll strobe with wrong address or bus driven");

   a_final_after_poll: assert property (
      @(posedge CLK_IN) disable iff (SRST_IN)
      (state_q == ST_FINAL && $past(state_q) != ST_FINAL) |->
      ($past(state_q) inside {ST_DP_A, ST_DP_B, ST_TG_B, ST_TG_C}) && $past(cyc_done))
      else $error("final read entered without a poll read");

   a_fail_recheck: assert property (
      @(posedge CLK_IN) disable iff (SRST_IN)
      (state_q == ST_DP_A && cyc_done && !dp_match && lim_fail) |=> (state_q == ST_DP_B))
      else $error("fail bit seen without rereading bit 7");

   a_reset_via_recheck: assert property (
      @(posedge CLK_IN) disable iff (SRST_IN)
      (state_q == ST_RESET && $past(state_q) != ST_RESET && op_q != OP_RESET) |->
      ($past(state_q) inside {ST_DP_B, ST_TG_C}))
      else $error("failure declared without a recheck");

   a_sector_mode: assert property (
      @(posedge CLK_IN) disable iff (SRST_IN)
      (state_q == ST_TG_B && cyc_done && !g_changed) |=> (stog_q == $past(s_changed)) && !gtog_q)
      else $error("sector toggle flag does not match bit 2");

   a_reset_cmd_sent: assert property (
      @(posedge CLK_IN) disable iff (SRST_IN)
      (state_q == ST_RESET && !issued_q) |-> ##[1:40] (!FL_WE_N_OUT && FL_DQ_OUT == CMD_RESET && !FL_DQ_DRV_N_OUT))
      else $error("reset command not written after failure");

endmodule : fws_status_poller
`default_nettype wire

/* File: pkg/fws_pkg.sv */
`default_nettype none
// ==========================================
// constants for the flash status poller
package fws_pkg;

   localparam int CLK_MHZ     = 100;
   localparam int T_PULSE_NS  = 100;
   localparam int T_RECOV_NS  = 50;
   localparam int FLASH_AW    = 18;
   localparam int POLL_MAX_DEF = 100000;

   // ==========================================
   // least times round up, never below one cycle
   function automatic int fws_ns_to_cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      if (c < 1)
      begin
         c = 1;
      end
      return c;
   endfunction : fws_ns_to_cyc

   localparam int PULSE_CYC = fws_ns_to_cyc(T_PULSE_NS);
   localparam int RECOV_CYC = fws_ns_to_cyc(T_RECOV_NS);

   // ==========================================
   // status bit positions on the flash data bus
   localparam int DATA_POLL_BIT         = 7;
   localparam int GLOBAL_TOGGLE_BIT     = 6;
   localparam int TIMING_LIMIT_FAIL_BIT = 5;
   localparam int SECTOR_TOGGLE_BIT     = 2;

   localparam logic [7:0] CMD_RESET = 8'hF0;

   // ==========================================
   // avalon register byte addresses
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h4;
   localparam logic [3:0] REG_DATA = 4'h8;
   localparam logic [3:0] REG_STAT = 4'hC;

   localparam int OP_W       = 3;
   localparam int STAT_BUSY  = 0;
   localparam int STAT_DONE  = 1;
   localparam int STAT_FAIL  = 2;
   localparam int STAT_TMO   = 3;
   localparam int STAT_GTOG  = 4;
   localparam int STAT_STOG  = 5;
   localparam int STAT_W     = 6;

   typedef enum logic [OP_W-1:0] {
      OP_NONE,
      OP_WRITE,
      OP_READ,
      OP_DPOLL,
      OP_TPOLL,
      OP_RESET
   } fws_op_t;

endpackage : fws_pkg
`default_nettype wire
